// File: link_seq_defs.vh
`ifndef LINK_SEQ_DEFS_VH
`define LINK_SEQ_DEFS_VH

// Sequence numbering
`define SEQ_W          7
`define SEQ_MODULUS    128
`define SEQ_ZERO       7'h00
`define SEQ_ONE        7'h01
`define WINDOW_MAX     7'h7f

// Unit kinds on the request and line sides
`define KIND_W         2
`define KIND_INFO      2'h0
`define KIND_SUPV      2'h1
`define KIND_OTHER     2'h2

// Request word layout held in the FIFO
`define TAG_W          8
`define REQ_W          12
`define REQ_TAG_LSB    0
`define REQ_TAG_MSB    7
`define REQ_CMD_BIT    8
`define REQ_PF_BIT     9
`define REQ_KIND_LSB   10
`define REQ_KIND_MSB   11

// Request FIFO shape
`define FIFO_DEPTH     4
`define FIFO_AW        2

`endif

// File: seq_fifo.v
`timescale 1ns/1ps
module seq_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_in_valid,
  output reg              o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  wire [AW:0]     next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and occupancy
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];
  assign next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  ////////////////////////////////////////////////////////////////////////////
  // Storage, pointers and a registered ready
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr     <= {AW{1'b0}};
      rd_ptr     <= {AW{1'b0}};
      count      <= {(AW+1){1'b0}};
      o_in_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr      <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      count      <= next_count;
      o_in_ready <= (next_count != DEPTH[AW:0]); // Honest full
    end
  end

endmodule

// File: link_sequence_control.v
// What this block does
// - Received connectionless command with poll 1 solicits a response with final 1.
// - Final-1 response leaves only when the response hold delay permits.
// - Each information unit carries a number from 0 to modulus minus one.
// - Sequence modulus is fixed at 128.
// - Numbers wrap from maximum back to zero, skipping none.
// - Unacknowledged information units never exceed 127; sending stalls at the limit.
// - One send-state and one receive-state counter per connection.
// - Send-state and receive-state counters update independently of each other.
// - Send-state counter holds number for next information unit sent.
// - Send-state advances per information unit, at most 127 past last ack.
// - Only information units carry a send-sequence number.
// - Outgoing information unit takes send-state counter as its send number.
// - Receive-state counter holds number expected on next information unit.
// - Receive-state advances only on error-free in-sequence information unit.
// - Information and supervisory units carry a receive-sequence number.
// - Outgoing receive number is loaded from the receive-state counter.
// - Received receive number acknowledges all units up to it minus one.
// - Frames failing the check sequence are discarded for sequencing.
`timescale 1ns/1ps
`include "link_seq_defs.vh"
module link_sequence_control (
  input  wire                I_CLK_SYS,
  input  wire                I_SYS_RST,
  input  wire                I_CONN_ESTABLISH,
  // Upper-layer transmit requests
  input  wire                I_REQ_VALID,
  output wire                O_REQ_READY,
  input  wire [`KIND_W-1:0]  I_REQ_KIND,
  input  wire                I_REQ_PF,
  input  wire                I_REQ_CMD,
  input  wire [`TAG_W-1:0]   I_REQ_TAG,
  // Outgoing unit header toward framing
  output reg                 O_TX_VALID,
  input  wire                I_TX_READY,
  output reg  [`KIND_W-1:0]  O_TX_KIND,
  output reg  [`SEQ_W-1:0]   O_TX_NS,
  output reg  [`SEQ_W-1:0]   O_TX_NR,
  output reg                 O_TX_PF,
  output reg                 O_TX_CMD,
  output reg  [`TAG_W-1:0]   O_TX_TAG,
  // Response hold delay permission
  input  wire                I_RESPONSE_HOLD_DELAY_OPEN,
  // Received unit header from deframing
  input  wire                I_RX_VALID,
  input  wire                I_RX_FCS_OK,
  input  wire [`KIND_W-1:0]  I_RX_KIND,
  input  wire [`SEQ_W-1:0]   I_RX_NS,
  input  wire [`SEQ_W-1:0]   I_RX_NR,
  input  wire                I_RX_PF,
  input  wire                I_RX_CMD,
  // Receive results
  output reg                 O_RX_ACCEPT,
  output reg                 O_RX_OUT_OF_SEQ,
  output reg                 O_RX_DISCARD,
  // Status
  output reg  [`SEQ_W-1:0]   O_SEND_STATE,
  output reg  [`SEQ_W-1:0]   O_RECV_STATE,
  output reg  [`SEQ_W-1:0]   O_ACK_NR,
  output reg  [`SEQ_W-1:0]   O_OUTSTANDING,
  output reg                 O_WINDOW_FULL,
  output reg                 O_FINAL_PENDING
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_OFFER = 1'b1;

  reg                 state;
  reg                 next_state;
  reg  [`SEQ_W-1:0]   send_state;
  reg  [`SEQ_W-1:0]   recv_state;
  reg  [`SEQ_W-1:0]   ack_nr;
  reg                 final_pending;
  wire [`REQ_W-1:0]   req_word;
  wire                head_valid;
  wire [`REQ_W-1:0]   head_word;
  wire [`KIND_W-1:0]  head_kind;
  wire                head_is_info;
  wire                head_final;
  wire                slot_free;
  wire                window_full;
  wire [`SEQ_W-1:0]   outstanding;
  wire                final_go;
  wire                head_go;
  wire                head_pop;
  wire                rx_good;
  wire                rx_bad;
  wire                rx_info;
  wire                rx_numbered;
  wire                rx_in_seq;
  wire [`SEQ_W-1:0]   rx_ack_span;
  wire                rx_ack_ok;
  wire                poll_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Request FIFO
  assign req_word = {I_REQ_KIND, I_REQ_PF, I_REQ_CMD, I_REQ_TAG};

  seq_fifo #(
    .WIDTH (`REQ_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_req_fifo (
    .i_clk       (I_CLK_SYS),
    .i_rst       (I_SYS_RST),
    .i_in_valid  (I_REQ_VALID),
    .o_in_ready  (O_REQ_READY),
    .i_in_data   (req_word),
    .o_out_valid (head_valid),
    .i_out_ready (head_pop),
    .o_out_data  (head_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Window accounting
  assign outstanding  = send_state - ack_nr;
  assign window_full  = (outstanding == `WINDOW_MAX);
  assign head_kind    = head_word[`REQ_KIND_MSB:`REQ_KIND_LSB];
  assign head_is_info = (head_kind == `KIND_INFO);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit arbitration: pending final response first, then the FIFO head
  assign slot_free = (state == ST_IDLE) | I_TX_READY;
  assign final_go  = slot_free & final_pending & I_RESPONSE_HOLD_DELAY_OPEN;
  // Queued responses with final 1 wait for the hold delay as well
  assign head_final = head_word[`REQ_PF_BIT] & ~head_word[`REQ_CMD_BIT];
  assign head_go   = slot_free & ~final_go & head_valid
                   & ~(head_is_info & window_full)
                   & ~(head_final & ~I_RESPONSE_HOLD_DELAY_OPEN);
  assign head_pop  = head_go;

  ////////////////////////////////////////////////////////////////////////////
  // Receive classification
  assign rx_good     = I_RX_VALID & I_RX_FCS_OK;
  assign rx_bad      = I_RX_VALID & ~I_RX_FCS_OK;
  assign rx_info     = (I_RX_KIND == `KIND_INFO);
  assign rx_numbered = rx_info | (I_RX_KIND == `KIND_SUPV);
  assign rx_in_seq   = (I_RX_NS == recv_state);
  // Acknowledge only within the range actually sent
  assign rx_ack_span = I_RX_NR - ack_nr;
  assign rx_ack_ok   = (rx_ack_span <= outstanding);
  assign poll_seen   = rx_good & (I_RX_KIND == `KIND_OTHER)
                     & I_RX_CMD & I_RX_PF;

  ////////////////////////////////////////////////////////////////////////////
  // Output slot state machine
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (final_go | head_go)
          next_state = ST_OFFER;
      end
      ST_OFFER:
      begin
        if (I_TX_READY & ~(final_go | head_go))
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send-state counter, own process so it never looks at receive state
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST | I_CONN_ESTABLISH)
      send_state <= `SEQ_ZERO;
    else if (head_go & head_is_info)
      send_state <= send_state + `SEQ_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive-state counter, independent of send state
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST | I_CONN_ESTABLISH)
      recv_state <= `SEQ_ZERO;
    else if (rx_good & rx_info & rx_in_seq)
      recv_state <= recv_state + `SEQ_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Last acknowledgement from the peer
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST | I_CONN_ESTABLISH)
      ack_nr <= `SEQ_ZERO;
    else if (rx_good & rx_numbered & rx_ack_ok)
      ack_nr <= I_RX_NR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Poll solicitation; a new poll wins over the clear by a send
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
      final_pending <= 1'b0;
    else if (poll_seen)
      final_pending <= 1'b1;
    else if (final_go)
      final_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing header registers
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      O_TX_VALID <= 1'b0;
      O_TX_KIND  <= `KIND_INFO;
      O_TX_NS    <= `SEQ_ZERO;
      O_TX_NR    <= `SEQ_ZERO;
      O_TX_PF    <= 1'b0;
      O_TX_CMD   <= 1'b0;
      O_TX_TAG   <= {`TAG_W{1'b0}};
    end
    else if (final_go)
    begin
      // Connectionless response carrying final 1
      O_TX_VALID <= 1'b1;
      O_TX_KIND  <= `KIND_OTHER;
      O_TX_NS    <= `SEQ_ZERO;
      O_TX_NR    <= `SEQ_ZERO;
      O_TX_PF    <= 1'b1;
      O_TX_CMD   <= 1'b0;
      O_TX_TAG   <= {`TAG_W{1'b0}};
    end
    else if (head_go)
    begin
      O_TX_VALID <= 1'b1;
      O_TX_KIND  <= head_kind;
      // Send number only on information units
      O_TX_NS    <= head_is_info ? send_state : `SEQ_ZERO;
      // Receive number on information and supervisory units
      O_TX_NR    <= (head_kind == `KIND_OTHER) ? `SEQ_ZERO
                                               : recv_state;
      O_TX_PF    <= head_word[`REQ_PF_BIT];
      O_TX_CMD   <= head_word[`REQ_CMD_BIT];
      O_TX_TAG   <= head_word[`REQ_TAG_MSB:`REQ_TAG_LSB];
    end
    else if (I_TX_READY)
      O_TX_VALID <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive result pulses
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      O_RX_ACCEPT     <= 1'b0;
      O_RX_OUT_OF_SEQ <= 1'b0;
      O_RX_DISCARD    <= 1'b0;
    end
    else
    begin
      O_RX_ACCEPT     <= rx_good & rx_info & rx_in_seq;
      O_RX_OUT_OF_SEQ <= rx_good & rx_info & ~rx_in_seq;
      O_RX_DISCARD    <= rx_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status mirrors
  always @(posedge I_CLK_SYS)
  begin
    if (I_SYS_RST)
    begin
      O_SEND_STATE    <= `SEQ_ZERO;
      O_RECV_STATE    <= `SEQ_ZERO;
      O_ACK_NR        <= `SEQ_ZERO;
      O_OUTSTANDING   <= `SEQ_ZERO;
      O_WINDOW_FULL   <= 1'b0;
      O_FINAL_PENDING <= 1'b0;
    end
    else
    begin
      O_SEND_STATE    <= send_state;
      O_RECV_STATE    <= recv_state;
      O_ACK_NR        <= ack_nr;
      O_OUTSTANDING   <= outstanding;
      O_WINDOW_FULL   <= window_full;
      O_FINAL_PENDING <= final_pending;
    end
  end

endmodule

// File: link_sequence_control_asserts.sv
`timescale 1ns/1ps
`include "link_seq_defs.vh"
module link_sequence_control_asserts (
  input logic                I_CLK_SYS,
  input logic                I_SYS_RST,
  input logic                I_CONN_ESTABLISH,
  input logic                O_TX_VALID,
  input logic                I_TX_READY,
  input logic [`KIND_W-1:0]  O_TX_KIND,
  input logic [`SEQ_W-1:0]   O_TX_NS,
  input logic                O_TX_PF,
  input logic                O_TX_CMD,
  input logic                I_RESPONSE_HOLD_DELAY_OPEN,
  input logic                I_RX_VALID,
  input logic                I_RX_FCS_OK,
  input logic                O_RX_ACCEPT,
  input logic                O_RX_DISCARD,
  input logic [`SEQ_W-1:0]   O_SEND_STATE,
  input logic [`SEQ_W-1:0]   O_RECV_STATE,
  input logic [`SEQ_W-1:0]   O_OUTSTANDING,
  input logic                O_WINDOW_FULL
);
  logic held;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  // Header left standing at the last edge
  always_ff @(posedge I_CLK_SYS)
    held <= !I_SYS_RST && O_TX_VALID && !I_TX_READY;
  ////////////////////////////////////////////////////////////
  a_ns_noninfo: assert property (O_TX_VALID && O_TX_KIND != `KIND_INFO
    |-> O_TX_NS == 7'h00) else $error("send number on non-information unit");
  a_hdr_hold: assert property (O_TX_VALID && !I_TX_READY
    |=> O_TX_VALID && $stable(O_TX_NS) && $stable(O_TX_KIND))
    else $error("header changed while waiting");
  a_ns_state: assert property (O_TX_VALID && !held && O_TX_KIND == `KIND_INFO
    |-> O_TX_NS == O_SEND_STATE) else $error("send number not send state");
  a_send_step: assert property (!$stable(O_SEND_STATE)
    && !$past(I_CONN_ESTABLISH, 2) |-> O_SEND_STATE == $past(O_SEND_STATE) + 7'h01)
    else $error("send state jumped");
  a_recv_step: assert property (O_RX_ACCEPT
    |=> O_RECV_STATE == $past(O_RECV_STATE) + 7'h01)
    else $error("receive state not advanced");
  a_recv_hold: assert property (!$stable(O_RECV_STATE)
    && !$past(I_CONN_ESTABLISH, 2) |-> $past(O_RX_ACCEPT))
    else $error("receive state moved without accept");
  a_fcs_drop: assert property (I_RX_VALID && !I_RX_FCS_OK
    |=> O_RX_DISCARD && !O_RX_ACCEPT) else $error("bad frame not discarded");
  a_window_flag: assert property (O_WINDOW_FULL == (O_OUTSTANDING == `WINDOW_MAX))
    else $error("window flag wrong");
  // A fresh information header never follows a full window
  a_window_stall: assert property (O_WINDOW_FULL && !held
    |-> !(O_TX_VALID && O_TX_KIND == `KIND_INFO))
    else $error("information unit sent at full window");
  // Any fresh response with final 1 was loaded while the hold delay was open
  a_final_gate: assert property (O_TX_VALID && !held && O_TX_PF && !O_TX_CMD
    |-> $past(I_RESPONSE_HOLD_DELAY_OPEN)) else $error("final sent while held");
endmodule
bind link_sequence_control link_sequence_control_asserts u_chk (.*);

// File: framing_peer.sv
`timescale 1ns/1ps
module framing_peer (
  input  wire  i_clk,
  input  wire  i_rst,
  output reg   o_ready
);
  reg [7:0] pat;
  // Takes headers with a shifting mix of prompt and stalled cycles
  always @(negedge i_clk)
  begin
    pat     <= i_rst ? 8'h5b : {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    o_ready <= !i_rst && (pat[1:0] != 2'h0);
  end
endmodule

// File: link_sequence_control_test.sv
`timescale 1ns/1ps
`include "link_seq_defs.vh"
module link_sequence_control_test;
  logic        clk = 1'b0, rst = 1'b1, est = 1'b0, hold_open = 1'b0;
  logic        rq_v = 1'b0, rq_pf = 1'b0, rq_cmd = 1'b0, rx_v = 1'b0, rx_ok = 1'b0;
  logic        rx_pf = 1'b0, rx_cmd = 1'b0;
  logic [1:0]  rq_kind = 2'h0, rx_kind = 2'h0;
  logic [7:0]  rq_tag = 8'h00;
  logic [6:0]  rx_ns = 7'h00, rx_nr = 7'h00, evs = 7'h00, evr = 7'h00, eack = 7'h00;
  wire         rq_rdy, tx_v, tx_rdy, tx_pf, tx_cmd, acc, oos, disc, full, fpend;
  wire  [1:0]  tx_kind;
  wire  [7:0]  tx_tag;
  wire  [6:0]  tx_ns, tx_nr, vs, vr, ack, outst;
  wire  [25:0] tx_hdr = {tx_kind, tx_pf, tx_cmd, tx_tag, tx_ns, tx_nr};
  logic [15:0] rnd = 16'h0041;
  logic [25:0] expq[$];
  int          num_errors = 0, n_tests = 0;
  link_sequence_control u_dut (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CONN_ESTABLISH(est), .I_REQ_VALID(rq_v),
    .O_REQ_READY(rq_rdy), .I_REQ_KIND(rq_kind), .I_REQ_PF(rq_pf), .I_REQ_CMD(rq_cmd),
    .I_REQ_TAG(rq_tag), .O_TX_VALID(tx_v), .I_TX_READY(tx_rdy), .O_TX_KIND(tx_kind),
    .O_TX_NS(tx_ns), .O_TX_NR(tx_nr), .O_TX_PF(tx_pf), .O_TX_CMD(tx_cmd), .O_TX_TAG(tx_tag),
    .I_RESPONSE_HOLD_DELAY_OPEN(hold_open), .I_RX_VALID(rx_v), .I_RX_FCS_OK(rx_ok),
    .I_RX_KIND(rx_kind), .I_RX_NS(rx_ns), .I_RX_NR(rx_nr), .I_RX_PF(rx_pf),
    .I_RX_CMD(rx_cmd), .O_RX_ACCEPT(acc), .O_RX_OUT_OF_SEQ(oos), .O_RX_DISCARD(disc),
    .O_SEND_STATE(vs), .O_RECV_STATE(vr), .O_ACK_NR(ack), .O_OUTSTANDING(outst),
    .O_WINDOW_FULL(full), .O_FINAL_PENDING(fpend));
  framing_peer u_peer (.i_clk(clk), .i_rst(rst), .o_ready(tx_rdy));
  // 100 MHz clock
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected header for a request taken now
  function automatic logic [25:0] hdr(input logic [1:0] k, input logic p, c, input logic [7:0] t);
    hdr = {k, p, c, t, k == `KIND_INFO ? evs : 7'h00, k == `KIND_OTHER ? 7'h00 : evr};
  endfunction
  task automatic chk(input string what, input logic [25:0] e, input logic [25:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One request, held until the FIFO takes it
  task automatic req(input logic [1:0] k, input logic p, c, input logic [7:0] t);
    int n = 0;
    rq_v = 1'b1;
    rq_kind = k;
    rq_pf = p;
    rq_cmd = c;
    rq_tag = t;
    while (!rq_rdy && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("ready", 26'h1, {25'h0, rq_rdy});
    expq.push_back(hdr(k, p, c, t));
    if (k == `KIND_INFO)
      evs++;
    @(negedge clk);
  endtask
  // One received header, then its result pulses and counters
  task automatic rx(input logic [1:0] k, input logic ok, p, c, input logic [6:0] ns, nr);
    logic good;
    good = ok && k == `KIND_INFO;
    rx_v = 1'b1;
    rx_kind = k;
    rx_ok = ok;
    rx_pf = p;
    rx_cmd = c;
    rx_ns = ns;
    rx_nr = nr;
    @(negedge clk);
    rx_v = 1'b0;
    chk("rx result", {good && ns == evr, good && ns != evr, !ok}, {acc, oos, disc});
    if (good && ns == evr)
      evr++;
    if (ok && k != `KIND_OTHER && 7'(nr - eack) <= 7'(evs - eack))
      eack = nr;
    repeat (2) @(negedge clk);
    chk("rx state", {evr, eack}, {vr, ack});
  endtask
  task automatic drain(input int left);
    int n = 0;
    while (expq.size() > left && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    chk("pending", 26'(left), 26'(expq.size()));
  endtask
  // Headers taken by framing, in order
  always @(posedge clk)
    if (tx_v === 1'b1 && tx_rdy === 1'b1)
      chk("header", expq.size() > 0 ? expq.pop_front() : '1,
          tx_hdr);
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    chk("reset", {1'b1, 1'b0, 7'h00, 7'h00}, {rq_rdy, tx_v, vs, vr});
    rst = 1'b0;
    repeat (24)
    begin
      rnd = lfsr(rnd);
      // Hold delay shut at random, opened whenever the queue is full
      hold_open = rnd[4] | !rq_rdy;
      req(rnd[1:0] == 2'h3 ? 2'h0 : rnd[1:0], rnd[2], rnd[1] | rnd[3], rnd[15:8]);
    end
    rq_v = 1'b0;
    hold_open = 1'b1;
    drain(0);
    repeat (16)
    begin
      rnd = lfsr(rnd);
      rx({1'b0, rnd[0]}, rnd[3:2] != 2'h0, 1'b0, rnd[5], rnd[4] ? evr : rnd[14:8],
         rnd[6] ? evs : rnd[13:7]);
    end
    est = 1'b1;
    @(negedge clk);
    est = 1'b0;
    repeat (3) @(negedge clk);
    chk("cleared", 26'h0, {5'h00, vs, vr, ack});
    chk("outstanding", 26'h0, {19'h0, outst});
    evs = 7'h00;
    evr = 7'h00;
    eack = 7'h00;
    hold_open = 1'b0;
    // Poll with bad check sequence, then a good one behind a closed hold delay
    rx(`KIND_OTHER, 1'b0, 1'b1, 1'b1, 7'h00, 7'h00);
    chk("no poll", 26'h0, {25'h0, fpend});
    rx(`KIND_OTHER, 1'b1, 1'b1, 1'b1, 7'h00, 7'h00);
    repeat (4) @(negedge clk);
    chk("poll", 26'h2, {24'h0, fpend, tx_v});
    expq.push_back(hdr(`KIND_OTHER, 1'b1, 1'b0, 8'h00));
    hold_open = 1'b1;
    drain(0);
    // Fill the window, stall the FIFO, then acknowledge and wrap
    repeat (128) req(`KIND_INFO, 1'b0, 1'b1, {1'b0, evs});
    repeat (3) req(`KIND_SUPV, 1'b1, 1'b0, 8'h5a);
    rq_v = 1'b0;
    drain(4);
    repeat (20) @(negedge clk);
    drain(4);
    chk("window", {1'b0, 1'b1, 7'h7f}, {rq_rdy, full, outst});
    evs--;
    rx(`KIND_SUPV, 1'b1, 1'b0, 1'b0, 7'h00, evs);
    evs++;
    repeat (4) req(`KIND_INFO, 1'b1, 1'b1, 8'hc3);
    rq_v = 1'b0;
    drain(0);
    close_out();
  end
  // Watchdog
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
